// *** dv/cmp_analog_model.sv ***
// Behavioural model of the analog sources and the two comparator cores.
`timescale 1ns/100ps
module cmp_analog_model (
  input wire logic clk_i,
  input wire cmp_pkg::analog_ctl_t [1:0] ctl_i,
  input wire logic [7:0] v_i [8],
  output logic [1:0] raw_o
);
  logic flip_q = 1'b0;
  logic [8:0] vn [2];
  logic [8:0] vp [2];
  // A dead core or a floating input must not look like a steady level, so it wanders.
  always @(posedge clk_i) flip_q <= ~flip_q;
  always_comb begin
    for (int c = 0; c < 2; c++) begin
      vn[c] = 9'h100;
      vp[c] = 9'h100;
      for (int i = 0; i < 4; i++) begin
        if (ctl_i[c].inv_pin[i]) vn[c] = {1'b0, v_i[i]};
      end
      for (int i = 0; i < 2; i++) begin
        if (ctl_i[c].ni_pin[i]) vp[c] = {1'b0, v_i[4 + i]};
      end
      if (ctl_i[c].inv_fvr) vn[c] = {1'b0, v_i[7]};
      if (ctl_i[c].inv_gnd) vn[c] = 9'h000;
      if (ctl_i[c].ni_dac) vp[c] = {1'b0, v_i[6]};
      if (ctl_i[c].ni_fvr) vp[c] = {1'b0, v_i[7]};
      if (ctl_i[c].ni_gnd) vp[c] = 9'h000;
      if (!ctl_i[c].power || vn[c][8] || vp[c][8]) raw_o[c] = flip_q ^ c[0];
      else raw_o[c] = vp[c] > vn[c];
    end
  end
endmodule

// *** dv/cmp_pair_ctrl_tb.sv ***
// Self-checking bench for the dual comparator control block.
`timescale 1ns/100ps
module cmp_pair_ctrl_tb;
  localparam logic [5:0] C0 = cmp_pkg::ADDR_CTRL0;
  localparam logic [5:0] C1 = cmp_pkg::ADDR_CTRL1;
  localparam logic [5:0] NS = cmp_pkg::ADDR_NSEL;
  localparam logic [5:0] PS = cmp_pkg::ADDR_PSEL;
  localparam logic [5:0] MR = cmp_pkg::ADDR_MIRROR;
  localparam logic [5:0] ST = cmp_pkg::ADDR_IRQ_STAT;
  localparam logic [5:0] MK = cmp_pkg::ADDR_IRQ_MASK;
  logic clk_i = 1'b0;
  logic arst_n_i = 1'b0;
  logic [5:0] addr = 6'h00;
  logic rd_en = 1'b0;
  logic wr_en = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic [3:0] be = 4'h0;
  logic [31:0] rdata;
  logic wait_req;
  logic [1:0] raw;
  logic tmr_clk = 1'b1;
  logic [4:0] adc_sel = 5'h00;
  cmp_pkg::analog_ctl_t [1:0] actl;
  logic [1:0] gate;
  logic adc_start;
  logic irq;
  logic [7:0] v [8] = '{default: 8'h40};
  int n_errors = 0;
  int n_checks = 0;

  initial forever #12.5 clk_i = ~clk_i;

  cmp_pair_ctrl dut_u (.clk_i(clk_i), .arst_n_i(arst_n_i), .avs_address_i(addr),
    .avs_read_i(rd_en), .avs_write_i(wr_en), .avs_writedata_i(wdata),
    .avs_byteenable_i(be), .avs_readdata_o(rdata), .avs_waitrequest_o(wait_req),
    .raw_cmp_i(raw), .tmr_clk_i(tmr_clk), .adc_trigger_select_i(adc_sel),
    .analog_ctl_o(actl), .cmp_gate_o(gate), .adc_start_o(adc_start), .irq_o(irq));
  cmp_analog_model ana_u (.clk_i(clk_i), .ctl_i(actl), .v_i(v), .raw_o(raw));

  task automatic stop_test();
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", s, e, g);
    end
  endtask

  // The request stays put until the rising edge that sees waitrequest low; read data
  // are taken at that same edge and the request is dropped only then.
  task automatic bus(input logic w, input logic [5:0] a, input logic [7:0] d,
                     input logic [3:0] b, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk_i);
    addr <= a;
    wdata <= {24'h0, d};
    be <= b;
    wr_en <= w;
    rd_en <= ~w;
    do begin
      @(posedge clk_i);
      n++;
    end while (wait_req !== 1'b0 && n < 50);
    q = rdata;
    if (wait_req !== 1'b0) begin
      n_errors++;
      stop_test();
    end
    wr_en <= 1'b0;
    rd_en <= 1'b0;
  endtask

  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, 4'h1, q);
  endtask

  task automatic rd(input string s, input logic [5:0] a, input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, 8'h00, 4'hf, q);
    chk(s, e, q);
  endtask

  task automatic setv(input logic hi);
    @(posedge clk_i);
    v[4] <= hi ? 8'h80 : 8'h20;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_i);
    @(negedge clk_i);
  endtask

  task automatic t_reset();
    for (int c = 0; c < 2; c++) begin
      rd("ctrl0", C0 + 6'(c * 16), 32'h04);
      rd("ctrl1", C1 + 6'(c * 16), 32'h0);
      rd("nsel", NS + 6'(c * 16), 32'h0);
      rd("psel", PS + 6'(c * 16), 32'h0);
    end
    rd("mirror", MR, 32'h0);
    rd("status", ST, 32'h0);
    rd("unmapped", 6'h2c, 32'h0);
    chk("irq", 32'h0, {31'h0, irq});
  endtask

  task automatic t_regs();
    logic [31:0] q;
    wr(C1, 8'hff);
    rd("ctrl1", C1, 32'h03);
    bus(1'b1, C1, 8'h00, 4'h0, q);
    rd("ctrl1 no lane", C1, 32'h03);
    wr(NS + 6'h10, 8'hff);
    rd("nsel", NS + 6'h10, 32'h07);
    wr(PS + 6'h10, 8'hff);
    rd("psel", PS + 6'h10, 32'h07);
    wr(C0, 8'h6b);
    rd("ctrl0", C0, 32'h07);
    wr(MR, 8'hff);
    wr(6'h30, 8'hff);
    rd("mirror ro", MR, 32'h0);
    wr(C1, 8'h00);
    wr(C0, 8'h00);
    wr(NS + 6'h10, 8'h00);
    wr(PS + 6'h10, 8'h00);
  endtask

  task automatic t_select();
    cmp_pkg::analog_ctl_t e;
    wr(C0, 8'h82);
    for (int k = 0; k < 8; k++) begin
      wr(NS, 8'(k));
      wr(PS, 8'(k));
      cyc(2);
      e = '0;
      e.inv_pin = (k < 4) ? 4'(1 << k) : 4'h0;
      e.inv_fvr = (k == 6);
      e.inv_gnd = (k == 7);
      e.ni_pin = (k < 2) ? 2'(1 << k) : 2'h0;
      e.ni_dac = (k == 5);
      e.ni_fvr = (k == 6);
      e.ni_gnd = (k == 7);
      e.hysteresis_enable = 1'b1;
      e.power = 1'b1;
      chk("analog ctl", 32'(e), 32'(actl[0]));
    end
    wr(C0, 8'h02);
    cyc(2);
    chk("analog off", 32'h0, 32'(actl[0]));
    wr(NS, 8'h00);
    wr(PS, 8'h00);
  endtask

  task automatic t_compare();
    setv(1'b1);
    // A core powers up one cycle after its enable, so its first result is not yet valid.
    wr(C0, 8'h80);
    cyc(1);
    rd("ctrl0 out", C0, 32'hc4);
    rd("mirror", MR, 32'h01);
    wr(C0 + 6'h10, 8'h80);
    cyc(1);
    rd("mirror", MR, 32'h03);
    wr(C0, 8'h90);
    rd("ctrl0 inv", C0, 32'h94);
    rd("mirror", MR, 32'h02);
    setv(1'b0);
    cyc(2);
    rd("ctrl0 swap", C0, 32'hd4);
    wr(C0 + 6'h10, 8'h00);
    wr(C0, 8'h80);
  endtask

  task automatic t_edges();
    wr(MK, 8'h01);
    wr(C1, 8'h02);
    wr(ST, 8'h03);
    setv(1'b1);
    cyc(1);
    chk("irq early", 32'h0, {31'h0, irq});
    cyc(1);
    chk("irq rise", 32'h1, {31'h0, irq});
    wr(MK, 8'h00);
    cyc(0);
    chk("irq masked", 32'h0, {31'h0, irq});
    wr(MK, 8'h01);
    wr(ST, 8'h01);
    rd("cleared", ST, 32'h0);
    setv(1'b0);
    cyc(3);
    rd("fall off", ST, 32'h0);
    wr(C1, 8'h01);
    setv(1'b1);
    cyc(3);
    rd("rise off", ST, 32'h0);
    setv(1'b0);
    cyc(3);
    rd("fall on", ST, 32'h1);
    wr(C1, 8'h03);
    wr(ST, 8'h01);
    // The rise pulse lands on the same clock as the clear.
    fork
      wr(ST, 8'h01);
      setv(1'b1);
    join
    rd("clear vs edge", ST, 32'h1);
    wr(ST, 8'h01);
    wr(C0, 8'h00);
    cyc(1);
    rd("enable off", ST, 32'h1);
    wr(ST, 8'h01);
    wr(C0, 8'h10);
    cyc(1);
    rd("polarity", ST, 32'h1);
    // Powering up may glitch, so the flag is cleared only once the core has settled.
    wr(C0, 8'h80);
    cyc(2);
    wr(ST, 8'h01);
    wr(C0, 8'h10);
    cyc(1);
    rd("no edge", ST, 32'h0);
    wr(C0, 8'h80);
    wr(C1, 8'h00);
  endtask

  task automatic t_gate();
    setv(1'b0);
    cyc(0);
    chk("gate async", 32'h0, {31'h0, gate[0]});
    wr(C0, 8'h81);
    setv(1'b1);
    cyc(4);
    chk("gate held", 32'h0, {31'h0, gate[0]});
    @(posedge clk_i);
    tmr_clk <= 1'b0;
    cyc(3);
    chk("gate fall", 32'h1, {31'h0, gate[0]});
    setv(1'b0);
    @(posedge clk_i);
    tmr_clk <= 1'b1;
    cyc(4);
    chk("gate rise", 32'h1, {31'h0, gate[0]});
    wr(C0, 8'h80);
    cyc(0);
    chk("gate async", 32'h0, {31'h0, gate[0]});
  endtask

  task automatic pulses(input int e);
    int n;
    n = 0;
    repeat (8) begin
      @(negedge clk_i);
      if (adc_start === 1'b1) n++;
    end
    chk("adc starts", 32'(e), 32'(n));
  endtask

  task automatic t_adc();
    @(posedge clk_i);
    adc_sel <= cmp_pkg::ADC_TRIG_CMP1;
    setv(1'b1);
    pulses(1);
    setv(1'b0);
    pulses(0);
    @(posedge clk_i);
    adc_sel <= cmp_pkg::ADC_TRIG_CMP2;
    setv(1'b1);
    pulses(0);
    setv(1'b0);
    wr(C0 + 6'h10, 8'h80);
    cyc(2);
    setv(1'b1);
    pulses(1);
  endtask

  initial begin
    repeat (10) @(posedge clk_i);
    arst_n_i <= 1'b1;
    t_reset();
    t_regs();
    t_select();
    t_compare();
    t_edges();
    t_gate();
    t_adc();
    stop_test();
  end

  initial begin
    repeat (20000) @(posedge clk_i);
    n_errors++;
    stop_test();
  end
endmodule

// *** hw/cmp_channel.sv ***
// Output path of one comparator: gating, polarity, latches and edge detect.
`timescale 1ns/100ps
module cmp_channel (
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire cmp_pkg::cmp_cfg_t cfg_i,
  input wire logic raw_i,
  input wire logic tmr_fall_i,
  output cmp_pkg::cmp_out_t out_o
);

  logic polarity_out;
  logic status_q;
  logic prev_q;
  logic ext_q;

  // A disabled comparator reads low before polarity, so toggling the
  // enable or the polarity can still make an edge.
  assign polarity_out = (cfg_i.en & raw_i) ^ cfg_i.polarity_select;

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      status_q <= 1'b0;
      prev_q <= 1'b0;
    end else begin
      status_q <= polarity_out;
      prev_q <= status_q;
    end
  end

  // The timer counts on its rising edge, so latching on the falling edge
  // keeps the gate steady while the count moves.
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ext_q <= 1'b0;
    end else if (tmr_fall_i) begin
      ext_q <= polarity_out;
    end
  end

  always_comb begin
    out_o.status = status_q;
    out_o.ext = cfg_i.sync ? ext_q : polarity_out;
    out_o.rise = status_q & ~prev_q;
    out_o.fall = ~status_q & prev_q;
  end

endmodule

// *** hw/cmp_pair_ctrl.sv ***
// Top of the dual comparator control block with its Avalon-MM registers.
`timescale 1ns/100ps
// Operation
// - Raw result is high when non-inverting input exceeds inverting input.
// - Enable bit powers the comparator; cleared means off, no active current.
// - Status bit returns the result after the polarity is applied.
// - Polarity bit inverts the output, same as swapping the inputs.
// - Hysteresis bit switches the analog hysteresis on or off.
// - Sync bit makes the gate and pin output follow the timer clock.
// - In sync mode the output latches on the timer clock falling edge.
// - Internal output registers every cycle; pin output is otherwise unlatched.
// - Fall enable lets a falling status edge set the interrupt flag.
// - Software clears the flag; a same-cycle enabled edge keeps it set.
// - Edges are seen even when disabled, from polarity or enable toggles.
// - Inverting select: pins 0-3, two unused, reference buffer, ground.
// - Non-inverting select: pins 0-1, three unused, converter output, buffer, ground.
// - Mirror register holds comparator 1 status in bit 0, 2 in bit 1.
// - Control 0 bit 2 reads one; other unused bits read zero.
// - Comparator output serves as a timer gate source.
// - A selected comparator's rising output starts a converter conversion.
module cmp_pair_ctrl (
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic [5:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  input wire logic [1:0] raw_cmp_i,
  input wire logic tmr_clk_i,
  input wire logic [4:0] adc_trigger_select_i,
  output cmp_pkg::analog_ctl_t [1:0] analog_ctl_o,
  output logic [1:0] cmp_gate_o,
  output logic adc_start_o,
  output logic irq_o
);

  cmp_pkg::bus_state_t state_q;
  cmp_pkg::bus_state_t state_d;
  cmp_pkg::cmp_cfg_t [1:0] cfg_q;
  cmp_pkg::cmp_out_t [1:0] cmp_out;
  logic [31:0] rdata_q;
  logic [31:0] rd_mux;
  logic [1:0] irq_stat_q;
  logic [1:0] irq_mask_q;
  logic [1:0] irq_set;
  logic [1:0] irq_clr;
  logic [1:0] mirror;
  logic wr_go;
  logic wr_low;
  logic tmr_clk_q;
  logic tmr_fall;
  logic adc_start_q;

  // Bus slave: every access takes one wait cycle, so read data can come
  // from a flop and a write lands on the edge where waitrequest is low.
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      cmp_pkg::BUS_IDLE: begin
        if (avs_read_i || avs_write_i) begin
          state_d = cmp_pkg::BUS_ACK;
        end
      end
      cmp_pkg::BUS_ACK: begin
        state_d = cmp_pkg::BUS_IDLE;
      end
      default: begin
        state_d = cmp_pkg::BUS_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state_q <= cmp_pkg::BUS_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  assign avs_waitrequest_o = (avs_read_i || avs_write_i) && (state_q != cmp_pkg::BUS_ACK);
  assign wr_go = (state_q == cmp_pkg::BUS_ACK) && avs_write_i;
  // Only the low byte holds fields; other lanes are accepted and dropped.
  assign wr_low = wr_go && avs_byteenable_i[0];

  assign mirror = {cmp_out[1].status, cmp_out[0].status};

  // Read decode; unmapped addresses return zero.
  always_comb begin
    rd_mux = '0;
    for (int ch = 0; ch < cmp_pkg::NUM_CMP; ch++) begin
      if (avs_address_i == cmp_pkg::ch_addr(cmp_pkg::ADDR_CTRL0, ch)) begin
        rd_mux[cmp_pkg::EN_BIT] = cfg_q[ch].en;
        rd_mux[cmp_pkg::OUT_BIT] = cmp_out[ch].status;
        rd_mux[cmp_pkg::POLARITY_BIT] = cfg_q[ch].polarity_select;
        rd_mux[cmp_pkg::ONE_BIT] = 1'b1;
        rd_mux[cmp_pkg::HYSTERESIS_BIT] = cfg_q[ch].hysteresis_enable;
        rd_mux[cmp_pkg::SYNC_BIT] = cfg_q[ch].sync;
      end
      if (avs_address_i == cmp_pkg::ch_addr(cmp_pkg::ADDR_CTRL1, ch)) begin
        rd_mux[cmp_pkg::RISE_BIT] = cfg_q[ch].rise_irq_enable;
        rd_mux[cmp_pkg::FALL_BIT] = cfg_q[ch].fall_irq_enable;
      end
      if (avs_address_i == cmp_pkg::ch_addr(cmp_pkg::ADDR_NSEL, ch)) begin
        rd_mux[cmp_pkg::SEL_MSB:0] = cfg_q[ch].inv_channel_sel;
      end
      if (avs_address_i == cmp_pkg::ch_addr(cmp_pkg::ADDR_PSEL, ch)) begin
        rd_mux[cmp_pkg::SEL_MSB:0] = cfg_q[ch].noninv_channel_sel;
      end
    end
    if (avs_address_i == cmp_pkg::ADDR_MIRROR) begin
      rd_mux[1:0] = mirror;
    end
    if (avs_address_i == cmp_pkg::ADDR_IRQ_STAT) begin
      rd_mux[1:0] = irq_stat_q;
    end
    if (avs_address_i == cmp_pkg::ADDR_IRQ_MASK) begin
      rd_mux[1:0] = irq_mask_q;
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rdata_q <= '0;
    end else if (state_q == cmp_pkg::BUS_IDLE && avs_read_i) begin
      rdata_q <= rd_mux;
    end
  end

  assign avs_readdata_o = rdata_q;

  // Configuration writes.
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cfg_q <= {cmp_pkg::CFG_RST, cmp_pkg::CFG_RST};
    end else begin
      for (int ch = 0; ch < cmp_pkg::NUM_CMP; ch++) begin
        if (wr_low && avs_address_i == cmp_pkg::ch_addr(cmp_pkg::ADDR_CTRL0, ch)) begin
          cfg_q[ch].en <= avs_writedata_i[cmp_pkg::EN_BIT];
          cfg_q[ch].polarity_select <= avs_writedata_i[cmp_pkg::POLARITY_BIT];
          cfg_q[ch].hysteresis_enable <= avs_writedata_i[cmp_pkg::HYSTERESIS_BIT];
          cfg_q[ch].sync <= avs_writedata_i[cmp_pkg::SYNC_BIT];
        end
        if (wr_low && avs_address_i == cmp_pkg::ch_addr(cmp_pkg::ADDR_CTRL1, ch)) begin
          cfg_q[ch].rise_irq_enable <= avs_writedata_i[cmp_pkg::RISE_BIT];
          cfg_q[ch].fall_irq_enable <= avs_writedata_i[cmp_pkg::FALL_BIT];
        end
        if (wr_low && avs_address_i == cmp_pkg::ch_addr(cmp_pkg::ADDR_NSEL, ch)) begin
          cfg_q[ch].inv_channel_sel <= avs_writedata_i[cmp_pkg::SEL_MSB:0];
        end
        if (wr_low && avs_address_i == cmp_pkg::ch_addr(cmp_pkg::ADDR_PSEL, ch)) begin
          cfg_q[ch].noninv_channel_sel <= avs_writedata_i[cmp_pkg::SEL_MSB:0];
        end
      end
    end
  end

  // The timer clock is sampled as a plain input; its falling edge is the
  // latch strobe for synchronous mode.
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      tmr_clk_q <= 1'b0;
    end else begin
      tmr_clk_q <= tmr_clk_i;
    end
  end

  assign tmr_fall = tmr_clk_q & ~tmr_clk_i;

  for (genvar g = 0; g < cmp_pkg::NUM_CMP; g++) begin : g_cmp
    cmp_channel u_channel (
      .clk_i(clk_i),
      .arst_n_i(arst_n_i),
      .cfg_i(cfg_q[g]),
      .raw_i(raw_cmp_i[g]),
      .tmr_fall_i(tmr_fall),
      .out_o(cmp_out[g])
    );
    cmp_sel_decode u_decode (
      .clk_i(clk_i),
      .arst_n_i(arst_n_i),
      .cfg_i(cfg_q[g]),
      .ctl_o(analog_ctl_o[g])
    );
    assign irq_set[g] = (cmp_out[g].rise & cfg_q[g].rise_irq_enable)
                      | (cmp_out[g].fall & cfg_q[g].fall_irq_enable);
    assign cmp_gate_o[g] = cmp_out[g].ext;
  end

  // Interrupt status: write one to clear, and a new event wins the race.
  assign irq_clr = (wr_low && avs_address_i == cmp_pkg::ADDR_IRQ_STAT) ?
                   avs_writedata_i[1:0] : 2'h0;

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      irq_stat_q <= 2'h0;
    end else begin
      irq_stat_q <= (irq_stat_q & ~irq_clr) | irq_set;
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      irq_mask_q <= 2'h0;
    end else if (wr_low && avs_address_i == cmp_pkg::ADDR_IRQ_MASK) begin
      irq_mask_q <= avs_writedata_i[1:0];
    end
  end

  assign irq_o = |(irq_stat_q & irq_mask_q);

  // Converter start pulse, one cycle, for the comparator it has selected.
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      adc_start_q <= 1'b0;
    end else begin
      adc_start_q <= (cmp_out[0].rise && adc_trigger_select_i == cmp_pkg::ADC_TRIG_CMP1)
                   || (cmp_out[1].rise && adc_trigger_select_i == cmp_pkg::ADC_TRIG_CMP2);
    end
  end

  assign adc_start_o = adc_start_q;

  sequence s_rd_ctrl0;
    state_q == cmp_pkg::BUS_IDLE && avs_read_i && avs_address_i == cmp_pkg::ADDR_CTRL0;
  endsequence

  sequence s_rd_done_one;
    !avs_waitrequest_o && avs_readdata_o[cmp_pkg::ONE_BIT];
  endsequence

  a_status_follow: assert property (
    @(posedge clk_i) disable iff (!arst_n_i)
    cmp_out[0].status == $past((cfg_q[0].en & raw_cmp_i[0]) ^ cfg_q[0].polarity_select))
    else $error("status does not follow the polarity-applied result");

  a_disabled_polarity: assert property (
    @(posedge clk_i) disable iff (!arst_n_i)
    !cfg_q[1].en ##1 !cfg_q[1].en |-> cmp_out[1].status == $past(cfg_q[1].polarity_select))
    else $error("disabled comparator does not show only the polarity");

  a_hysteresis_power: assert property (
    @(posedge clk_i) disable iff (!arst_n_i)
    cfg_q[0].en && cfg_q[0].hysteresis_enable |=>
      analog_ctl_o[0].hysteresis_enable && analog_ctl_o[0].power)
    else $error("hysteresis or power not driven for an enabled comparator");

  a_sync_hold: assert property (
    @(posedge clk_i) disable iff (!arst_n_i)
    cfg_q[0].sync && $past(cfg_q[0].sync) && !$past(tmr_fall) |-> $stable(cmp_gate_o[0]))
    else $error("synchronous gate moved without a timer falling edge");

  a_sync_latch: assert property (
    @(posedge clk_i) disable iff (!arst_n_i)
    tmr_fall ##1 cfg_q[0].sync |->
      cmp_gate_o[0] == $past((cfg_q[0].en & raw_cmp_i[0]) ^ cfg_q[0].polarity_select))
    else $error("synchronous gate did not latch at the timer falling edge");

  a_async_pass: assert property (
    @(posedge clk_i) disable iff (!arst_n_i)
    !cfg_q[1].sync |->
      cmp_gate_o[1] == ((cfg_q[1].en & raw_cmp_i[1]) ^ cfg_q[1].polarity_select))
    else $error("asynchronous gate is not the live result");

  a_rise_flag: assert property (
    @(posedge clk_i) disable iff (!arst_n_i)
    cmp_out[0].rise && cfg_q[0].rise_irq_enable |=> irq_stat_q[0])
    else $error("enabled rising edge did not set the flag");

  a_no_event_flag: assert property (
    @(posedge clk_i) disable iff (!arst_n_i)
    !irq_stat_q[0] && !irq_set[0] |=> !irq_stat_q[0])
    else $error("flag set with no enabled edge");

  a_set_wins: assert property (
    @(posedge clk_i) disable iff (!arst_n_i)
    irq_set[0] && irq_clr[0] |=> irq_stat_q[0] ##1 1'b1)
    else $error("clear beat a same-cycle edge");

  a_rise_pulse: assert property (
    @(posedge clk_i) disable iff (!arst_n_i)
    cmp_out[1].rise == $rose(cmp_out[1].status))
    else $error("rise pulse does not match the status change");

  a_adc_start: assert property (
    @(posedge clk_i) disable iff (!arst_n_i)
    cmp_out[0].rise && adc_trigger_select_i == cmp_pkg::ADC_TRIG_CMP1 |=> adc_start_o)
    else $error("converter start missing after a selected rising edge");

  a_ctrl0_one: assert property (
    @(posedge clk_i) disable iff (!arst_n_i)
    s_rd_ctrl0 |=> s_rd_done_one)
    else $error("control register 0 bit 2 did not read one");

  a_irq_level: assert property (
    @(posedge clk_i) disable iff (!arst_n_i)
    $rose(irq_o) |->
      $past(|irq_set) || $past(wr_low && avs_address_i == cmp_pkg::ADDR_IRQ_MASK))
    else $error("interrupt output rose with no event and no mask write");

endmodule

// *** hw/cmp_pkg.sv ***
// Shared constants, types and helpers for the dual comparator control block.
package cmp_pkg;

  localparam int NUM_CMP = 2;

  // Byte addresses of the register map; each channel repeats at a stride.
  localparam logic [5:0] ADDR_CTRL0 = 6'h00;
  localparam logic [5:0] ADDR_CTRL1 = 6'h04;
  localparam logic [5:0] ADDR_NSEL = 6'h08;
  localparam logic [5:0] ADDR_PSEL = 6'h0c;
  localparam logic [5:0] CH_STRIDE = 6'h10;
  localparam logic [5:0] ADDR_MIRROR = 6'h20;
  localparam logic [5:0] ADDR_IRQ_STAT = 6'h24;
  localparam logic [5:0] ADDR_IRQ_MASK = 6'h28;

  // Field positions.
  localparam int EN_BIT = 7;
  localparam int OUT_BIT = 6;
  localparam int POLARITY_BIT = 4;
  localparam int ONE_BIT = 2;
  localparam int HYSTERESIS_BIT = 1;
  localparam int SYNC_BIT = 0;
  localparam int RISE_BIT = 1;
  localparam int FALL_BIT = 0;
  localparam int SEL_MSB = 2;

  // Channel select encodings.
  localparam logic [2:0] NSEL_PIN_END = 3'h4;
  localparam logic [2:0] PSEL_PIN_END = 3'h2;
  localparam logic [2:0] PSEL_DAC = 3'h5;
  localparam logic [2:0] SEL_FVR = 3'h6;
  localparam logic [2:0] SEL_GND = 3'h7;

  // Auto-trigger codes of the converter that name each comparator.
  localparam logic [4:0] ADC_TRIG_CMP1 = 5'h0d;
  localparam logic [4:0] ADC_TRIG_CMP2 = 5'h0e;

  typedef enum logic [1:0] {
    BUS_IDLE = 2'b01,
    BUS_ACK = 2'b10
  } bus_state_t;

  typedef struct packed {
    logic en;
    logic polarity_select;
    logic hysteresis_enable;
    logic sync;
    logic rise_irq_enable;
    logic fall_irq_enable;
    logic [2:0] inv_channel_sel;
    logic [2:0] noninv_channel_sel;
  } cmp_cfg_t;

  localparam cmp_cfg_t CFG_RST = '0;

  typedef struct packed {
    logic [3:0] inv_pin;
    logic inv_fvr;
    logic inv_gnd;
    logic [1:0] ni_pin;
    logic ni_dac;
    logic ni_fvr;
    logic ni_gnd;
    logic hysteresis_enable;
    logic power;
  } analog_ctl_t;

  typedef struct packed {
    logic status;
    logic ext;
    logic rise;
    logic fall;
  } cmp_out_t;

  // Address of a channel register, used by both the read and write decode.
  function automatic logic [5:0] ch_addr(logic [5:0] base, int ch);
    ch_addr = base + 6'(ch * 16);
  endfunction

endpackage

// *** hw/cmp_sel_decode.sv ***
// Registered decode of the channel selects into analog switch enables.
`timescale 1ns/100ps
module cmp_sel_decode (
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire cmp_pkg::cmp_cfg_t cfg_i,
  output cmp_pkg::analog_ctl_t ctl_o
);

  cmp_pkg::analog_ctl_t ctl_d;

  // A disabled comparator closes no input switch, so it draws no current.
  always_comb begin
    ctl_d = '0;
    ctl_d.power = cfg_i.en;
    ctl_d.hysteresis_enable = cfg_i.en & cfg_i.hysteresis_enable;
    if (cfg_i.en) begin
      if (cfg_i.inv_channel_sel < cmp_pkg::NSEL_PIN_END) begin
        ctl_d.inv_pin[cfg_i.inv_channel_sel[1:0]] = 1'b1;
      end
      ctl_d.inv_fvr = (cfg_i.inv_channel_sel == cmp_pkg::SEL_FVR);
      ctl_d.inv_gnd = (cfg_i.inv_channel_sel == cmp_pkg::SEL_GND);
      if (cfg_i.noninv_channel_sel < cmp_pkg::PSEL_PIN_END) begin
        ctl_d.ni_pin[cfg_i.noninv_channel_sel[0]] = 1'b1;
      end
      ctl_d.ni_dac = (cfg_i.noninv_channel_sel == cmp_pkg::PSEL_DAC);
      ctl_d.ni_fvr = (cfg_i.noninv_channel_sel == cmp_pkg::SEL_FVR);
      ctl_d.ni_gnd = (cfg_i.noninv_channel_sel == cmp_pkg::SEL_GND);
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ctl_o <= '0;
    end else begin
      ctl_o <= ctl_d;
    end
  end

endmodule
